// ==== logic/pe_write_framer_pkg.sv ====
// Constants, types and register map for the phase-encoded write framer
package pe_write_framer_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control fields
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_MARK_BIT = 1;

  // Status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RWA_BIT   = 3;
  localparam int ST_MARK_WRITE_IN_PROGRESS_BIT = 4;
  localparam int ST_IDB_BIT   = 5;
  localparam int ST_ACCEL_BIT = 6;
  localparam int ST_PWE_BIT   = 7;
  localparam int ST_CHARS_LSB = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Character counts
  localparam logic [6:0] PREAMBLE_CHARS = 7'h28;
  localparam logic [6:0] RECORD_END_CHARS = 7'h50;

  // Buffer forcing
  localparam logic [8:0] MARK_KEEP_MASK = 9'h127;
  localparam logic [8:0] ALL_ONES_CHAR  = 9'h1ff;
  localparam int         PARITY_BIT     = 8;

  // Timing, milliseconds and clock rate
  localparam longint CLK_KHZ         = 125000;
  localparam longint T_BOT_DELAY_MS  = 202;
  localparam longint T_IDB_START_MS  = 56;
  localparam longint T_IDB_LEN_MS    = 130;
  localparam int BOT_DELAY_CYC  = int'(T_BOT_DELAY_MS * CLK_KHZ);
  localparam int IDB_START_CYC  = int'(T_IDB_START_MS * CLK_KHZ);
  localparam int IDB_LEN_CYC    = int'(T_IDB_LEN_MS * CLK_KHZ);
  localparam int START_DELAY_CYC = 1000;

  // Write major states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_MOTION,
    SEQ_PRE0,
    SEQ_PRE1,
    SEQ_DATA,
    SEQ_POS1,
    SEQ_POS_GAP,
    SEQ_POS0
  } seq_state_t;

endpackage : pe_write_framer_pkg

// ==== logic/pe_tape_write_framer.sv ====
// Phase-encoded write sequencer: preamble, postamble, tape mark, id burst
`timescale 1ns/1ps
module pe_tape_write_framer
  import pe_write_framer_pkg::*;
#(
  parameter int unsigned START_DELAY = START_DELAY_CYC,
  parameter int unsigned BOT_DELAY   = BOT_DELAY_CYC,
  parameter int unsigned IDB_START   = IDB_START_CYC,
  parameter int unsigned IDB_LEN     = IDB_LEN_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        transport_write_clock,
  input  wire logic        beginning_of_tape,
  input  wire logic [7:0]  char_data,
  input  wire logic        frame_count_overflow,
  output logic [8:0]       write_data,
  output logic             record_pulse,
  output logic             buffer_load_clock,
  output logic             phase_clock,
  output logic             accelerating,
  output logic             heads_enable,
  output logic             char_request,
  output logic             phase_write_enable
);

  // All module state in one record
  typedef struct packed {
    // Pin synchronisers
    logic [1:0]  wclk_sync;
    logic        wclk_prev;
    logic [1:0]  bot_sync;
    // Sequencer flags, counters and write buffer
    seq_state_t  st;
    logic        record_write_active;
    logic        mark_write_in_progress;
    logic        id_burst_active;
    logic        from_bot;
    logic        write_file_mark_cmd;
    logic [31:0] delay;
    logic [6:0]  chars;
    logic        half;
    logic [8:0]  wbuf;
    logic        rec;
    logic        blc;
    logic        req;
    logic        accel;
    logic        heads;
    logic        pwe;
    // Register bus channels
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  // Odd parity over a data character
  // always odd in this mode
  function automatic logic odd_parity(input logic [7:0] c);
    odd_parity = ~(^c);
  endfunction : odd_parity

  // Character the write multiplexer offers for the current major state
  function automatic logic [8:0] mux_char(input seq_state_t s,
                                          input logic [7:0] c);
    case (s)
      SEQ_DATA: mux_char = {odd_parity(c), c};
      SEQ_PRE1,
      SEQ_POS1: mux_char = ALL_ONES_CHAR;
      // Preamble and postamble zeros carry a zero parity bit
      default:  mux_char = 9'h000;
    endcase
  endfunction : mux_char

  // Next-state logic for bus, synchronisers and sequencer
  always_comb begin
    logic        wrise;
    logic        load;
    logic        tick;
    logic        go;
    logic [6:0]  chars_inc;
    logic [8:0]  nbuf;
    wrise     = 1'b0;
    load      = 1'b0;
    tick      = 1'b0;
    go        = 1'b0;
    chars_inc = 7'h00;
    nbuf      = 9'h000;
    d = q;

    // Pins pass two flops; edge found on the second stage only
    d.wclk_sync = {q.wclk_sync[0], transport_write_clock};
    d.wclk_prev = q.wclk_sync[1];
    // Tape position is a level, looked at only when a write starts
    d.bot_sync  = {q.bot_sync[0], beginning_of_tape};
    // Edge found between stage two and its delayed copy, never stage one
    wrise = q.wclk_sync[1] & ~q.wclk_prev;

    // Pulses last one cycle
    d.rec = 1'b0;
    d.blc = 1'b0;
    d.req = 1'b0;

    // Write address and data channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Response waits until both halves of the write are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if (q.waddr[7:2] == CTRL_OFS[7:2]) begin
        d.bresp = RESP_OKAY;
        // Only byte lane zero carries command bits
        // Command bits only change while the sequencer is idle
        if (q.wstrb[0] && q.st == SEQ_IDLE) begin
          d.write_file_mark_cmd = q.wdata[CTRL_MARK_BIT];
          go = q.wdata[CTRL_GO_BIT];
        end
      end else if (q.waddr[7:2] == STATUS_OFS[7:2]) begin
        d.bresp = RESP_OKAY;  // Status is read only; write ignored
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // Unmapped reads answer zero data with an error
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[7:2] == CTRL_OFS[7:2]) begin
        d.rdata[CTRL_MARK_BIT] = q.write_file_mark_cmd;
      end else if (s_axi_araddr[7:2] == STATUS_OFS[7:2]) begin
        d.rdata[ST_STATE_LSB +: 3] = q.st;
        d.rdata[ST_RWA_BIT]        = q.record_write_active;
        d.rdata[ST_MARK_WRITE_IN_PROGRESS_BIT]      = q.mark_write_in_progress;
        d.rdata[ST_IDB_BIT]        = q.id_burst_active;
        d.rdata[ST_ACCEL_BIT]      = q.accel;
        d.rdata[ST_PWE_BIT]        = q.pwe;
        d.rdata[ST_CHARS_LSB +: 7] = q.chars;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end

    // A level or a one-cycle pulse both clear the flag
    // overflow ends the data record
    if (frame_count_overflow) begin
      d.record_write_active = 1'b0;
    end

    // Buffer load on each rising transport clock edge while enabled
    // Two loads make one character; the tick marks the second
    load = wrise & q.pwe;
    if (load) begin
      nbuf = q.half ? ~q.wbuf : mux_char(q.st, char_data);
      // Burst ignores the multiplexer altogether
      // burst leaves only a toggling parity bit
      if (q.id_burst_active) begin
        nbuf = 9'h000;
        nbuf[PARITY_BIT] = ~q.wbuf[PARITY_BIT];
      end
      // mark command forces four bits clear
      if (q.write_file_mark_cmd) begin
        nbuf = nbuf & MARK_KEEP_MASK;
      end
      d.wbuf = nbuf;
      d.half = ~q.half;
      d.rec  = 1'b1;
      d.blc  = 1'b1;
      tick   = q.half;  // Second half closes a character
    end
    chars_inc = q.chars + 7'h01;

    // Write major-state sequencer
    case (q.st)
      SEQ_IDLE: begin
        if (go) begin
          // drive set energizes heads until the operation ends and starts accelerating
          d.heads = 1'b1;
          d.accel = 1'b1;
          // tape-mark write marks itself in progress
          d.mark_write_in_progress = d.write_file_mark_cmd;
          d.record_write_active    = ~d.write_file_mark_cmd;
          // write from beginning of tape adds the burst
          d.from_bot = q.bot_sync[1];
          // Counters restart for every operation
          d.delay    = 32'h0000_0000;
          d.chars    = 7'h00;
          d.half     = 1'b0;
          d.st       = SEQ_MOTION;
        end
      end
      SEQ_MOTION: begin
        // Counter is wide enough for the longest start delay
        d.delay = q.delay + 32'h0000_0001;
        if (q.from_bot) begin
          // burst window inside the longer delay
          if (q.delay == 32'(IDB_START - 1)) begin
            d.id_burst_active = 1'b1;
            // burst releases the transport write clock
            d.accel = 1'b0;
            d.half  = 1'b0;
          end
          if (q.delay == 32'(IDB_START + IDB_LEN - 1)) begin
            d.id_burst_active = 1'b0;
          end
        end
        // 202 ms delay from beginning of tape
        if ((q.from_bot && q.delay == 32'(BOT_DELAY - 1)) ||
            (!q.from_bot && q.delay == 32'(START_DELAY - 1))) begin
          // Record and mark both enter preamble zeros here
          // enabled sequencer sets preamble zeros
          d.accel = 1'b0;
          d.id_burst_active = 1'b0;
          d.chars = 7'h00;
          d.half  = 1'b0;
          d.st    = SEQ_PRE0;
        end
      end
      SEQ_PRE0: begin
        if (tick) begin
          d.chars = chars_inc;
          // forty characters, same counter as preamble
          if (chars_inc == PREAMBLE_CHARS) begin
            if (q.mark_write_in_progress) begin
              d.mark_write_in_progress = 1'b0;
              d.heads = 1'b0;
              d.st    = SEQ_IDLE;
            end else begin
              d.st = SEQ_PRE1;
            end
          end
        end
      end
      SEQ_PRE1: begin
        // One ones character, then the data phase
        if (tick) begin
          d.st  = SEQ_DATA;
          d.req = 1'b1;
        end
      end
      SEQ_DATA: begin
        if (tick) begin
          // Overflow seen mid-character still finishes the character
          // inactive record moves to postamble ones
          if (!q.record_write_active) begin
            d.st = SEQ_POS1;
          end else begin
            d.req = 1'b1;  // Ask source for next character
          end
        end
      end
      SEQ_POS1: begin
        // ones select held in this state via the multiplexer
        if (tick) begin
          // drop ones, one zero before counting
          d.st = SEQ_POS_GAP;
        end
      end
      SEQ_POS_GAP: begin
        // Zero character between ones and counted zeros, not counted
        if (tick) begin
          d.st = SEQ_POS0;
        end
      end
      SEQ_POS0: begin
        if (tick) begin
          // count from forty up to eighty
          d.chars = chars_inc;
          if (chars_inc == RECORD_END_CHARS) begin
            // Heads drop with the last zero; no erase left running
            d.heads = 1'b0;
            d.st    = SEQ_IDLE;
          end
        end
      end
      // All eight codes are states; the default still falls back to idle rather than lock up
      default: begin
        d.st = SEQ_IDLE;
      end
    endcase

    // phase write enable from major states and the id burst
    d.pwe = (d.st != SEQ_IDLE && d.st != SEQ_MOTION) | d.id_burst_active;

    // Ready only when nothing is held, so a response never overlaps
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;
    // Read ready falls while data waits to be taken
    d.arready = ~d.rvalid;
  end

  // Idle is code zero, so no pulse or enable follows release
  // synchronous reset clears every flag and pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Register bus outputs straight from the state record
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_arready      = q.arready;
  assign s_axi_rdata        = q.rdata;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rvalid       = q.rvalid;

  // Tape side outputs, also registered
  assign write_data         = q.wbuf;
  assign record_pulse       = q.rec;
  assign buffer_load_clock  = q.blc;
  assign phase_clock        = q.half;

  // Transport control levels and the character request pulse
  assign accelerating       = q.accel;
  assign heads_enable       = q.heads;
  assign char_request       = q.req;
  assign phase_write_enable = q.pwe;

endmodule : pe_tape_write_framer

// ==== sim/pe_write_framer_asserts.sv ====
// Concurrent checks on the phase-encoded write framer ports
`timescale 1ns/1ps
module pe_write_framer_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        transport_write_clock,
  input wire logic [8:0]  write_data,
  input wire logic        record_pulse,
  input wire logic        buffer_load_clock,
  input wire logic        phase_clock,
  input wire logic        accelerating,
  input wire logic        heads_enable,
  input wire logic        phase_write_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Master stalling a response
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_rwait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_RESET_QUIET: assert property (
    $rose(aresetn) |-> !record_pulse && !phase_write_enable &&
      !accelerating && !heads_enable) else $error("busy after reset");
  AST_REC_WITH_LOAD: assert property (
    record_pulse |-> buffer_load_clock) else $error("lone record pulse");
  AST_REC_ENABLED: assert property (
    record_pulse |-> phase_write_enable || $past(phase_write_enable))
    else $error("record pulse while disabled");
  AST_PULSE_ONE: assert property (
    record_pulse |=> !record_pulse[*3]) else $error("pulse too long");
  AST_NO_ACCEL_PWE: assert property (
    phase_write_enable |-> !accelerating) else $error("enable accelerating");
  AST_HEADS_PWE: assert property (
    phase_write_enable |-> heads_enable) else $error("enable without heads");
  AST_EDGE_TO_LOAD: assert property (
    buffer_load_clock |-> $past(transport_write_clock, 2))
    else $error("load without write clock");
  AST_DATA_ON_LOAD: assert property (
    $changed(write_data) |-> buffer_load_clock)
    else $error("buffer moved between loads");
  AST_PHASE_TOGGLE: assert property (
    buffer_load_clock |-> $changed(phase_clock))
    else $error("phase did not alternate");
  // Responses stand until taken
  AST_BVALID_HOLD: assert property (
    s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (
    s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : pe_write_framer_asserts

bind pe_tape_write_framer pe_write_framer_asserts chk_i (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .transport_write_clock, .write_data, .record_pulse,
  .buffer_load_clock, .phase_clock, .accelerating, .heads_enable,
  .phase_write_enable);

// ==== sim/tape_transport_model.sv ====
// Behavioural tape transport: write clock source and record capture
`timescale 1ns/1ps
module tape_transport_model (
  input  wire logic       aclk,
  input  wire logic       heads_enable,
  input  wire logic       accelerating,
  input  wire logic       record_pulse,
  input  wire logic [8:0] write_data,
  output logic            transport_write_clock
);
  logic [8:0] cap[$];
  // clock only at speed; stands low otherwise, odd phase to aclk
  initial begin
    transport_write_clock = 1'b0;
    #13;
    forever begin
      #40;
      if ((heads_enable && !accelerating) || transport_write_clock)
        transport_write_clock = ~transport_write_clock;
    end
  end
  // Each record pulse puts the buffer on tape
  always @(posedge aclk)
    if (record_pulse) cap.push_back(write_data);
endmodule : tape_transport_model

// ==== sim/pe_tape_write_framer_tb.sv ====
// Self-checking bench for the phase-encoded write framer
`timescale 1ns/1ps
module pe_tape_write_framer_tb;
  import pe_write_framer_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, transport_write_clock;
  logic beginning_of_tape, frame_count_overflow, record_pulse;
  logic buffer_load_clock, accelerating, heads_enable, phase_write_enable;
  logic char_request;
  logic [7:0] s_axi_awaddr, s_axi_araddr, char_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] write_data;
  int miscompares, comparisons, cycles, reqs;
  pe_tape_write_framer #(.START_DELAY(200), .BOT_DELAY(100),
    .IDB_START(20), .IDB_LEN(50)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .transport_write_clock, .beginning_of_tape, .char_data,
    .frame_count_overflow, .write_data, .record_pulse, .buffer_load_clock,
    .phase_clock(), .accelerating, .heads_enable, .char_request,
    .phase_write_enable);
  tape_transport_model transport (.aclk, .heads_enable, .accelerating,
    .record_pulse, .write_data, .transport_write_clock);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard, well above the longest run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // Character requests seen during the data phase
  always @(posedge aclk)
    if (char_request) reqs++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_load(input int i, input logic [8:0] v);
    logic [8:0] g;
    g = (i >= 0 && i < transport.cap.size()) ? transport.cap[i] : {9{1'bx}};
    chk({23'h0, g}, {23'h0, v});
  endtask : chk_load
  // Both write channels offered together, released as each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    st = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : axi_rd
  task automatic wait_state(input logic [2:0] s);
    for (int t = 0; t < 500; t++) begin
      axi_rd(STATUS_OFS, RESP_OKAY);
      if (st[2:0] === s) break;
    end
    chk({29'h0, st[2:0]}, {29'h0, s});
  endtask : wait_state
  // Data phase, then overflow closes the record
  task automatic run_frame;
    int n;
    reqs = 0;
    wait_state(3'h4);
    n = transport.cap.size() + 8;
    for (int t = 0; t < 400 && transport.cap.size() < n; t++) @(posedge aclk);
    frame_count_overflow <= 1'b1;
    @(posedge aclk);
    frame_count_overflow <= 1'b0;
    axi_rd(STATUS_OFS, RESP_OKAY);
    chk({31'h0, st[ST_RWA_BIT]}, 32'h0);
    wait_state(3'h5);
    wait_state(3'h0);
    chk({31'h0, phase_write_enable}, 32'h0);
  endtask : run_frame
  task automatic check_frame(input int b);
    int n;
    n = transport.cap.size();
    chk(reqs, (n - 84 - b - 82) / 2);
    for (int c = 0; c < 40; c++) begin
      chk_load(b + 2 * c, 9'h000);
      chk_load(b + 2 * c + 1, 9'h1ff);
      chk_load(n - 80 + 2 * c, 9'h000);
      chk_load(n - 79 + 2 * c, 9'h1ff);
    end
    chk_load(b + 80, ALL_ONES_CHAR);
    chk_load(b + 81, 9'h000);
    chk_load(n - 84, ALL_ONES_CHAR);
    chk_load(n - 83, 9'h000);
    chk_load(n - 82, 9'h000);
    chk_load(n - 81, 9'h1ff);
    for (int i = b + 82; i < n - 84; i += 2) begin
      chk_load(i, 9'h103);
      chk_load(i + 1, 9'h0fc);
    end
  endtask : check_frame
  task automatic test_regs;
    axi_rd(STATUS_OFS, RESP_OKAY);
    chk(st, 32'h0);
    axi_rd(8'h08, RESP_SLVERR);
    axi_wr(8'h0c, 32'h1, RESP_SLVERR);
    $display("test regs done");
  endtask : test_regs
  task automatic test_record;
    transport.cap.delete();
    axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
    run_frame;
    check_frame(0);
    $display("test record done");
  endtask : test_record
  task automatic test_mark;
    transport.cap.delete();
    axi_wr(CTRL_OFS, 32'h3, RESP_OKAY);
    axi_rd(STATUS_OFS, RESP_OKAY);
    chk({31'h0, st[ST_MARK_WRITE_IN_PROGRESS_BIT]}, 32'h1);
    chk({30'h0, heads_enable, accelerating}, 32'h3);
    wait_state(3'h0);
    chk(transport.cap.size(), 32'd80);
    for (int i = 0; i < 80; i += 2) begin
      chk_load(i, 9'h000);
      chk_load(i + 1, MARK_KEEP_MASK);
    end
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    $display("test mark done");
  endtask : test_mark
  task automatic test_burst;
    int k;
    logic p;
    beginning_of_tape <= 1'b1;
    transport.cap.delete();
    repeat (4) @(posedge aclk);
    axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
    repeat (25) @(posedge aclk);
    axi_rd(STATUS_OFS, RESP_OKAY);
    chk({26'h0, st[7:5], st[2:0]}, 32'h29);
    repeat (45) @(posedge aclk);
    axi_rd(STATUS_OFS, RESP_OKAY);
    chk({26'h0, st[7:5], st[2:0]}, 32'h01);
    run_frame;
    k = 0;
    while (k < transport.cap.size() && transport.cap[k] !== 9'h1ff) k++;
    k = k - 1;
    chk({31'h0, k >= 2}, 32'h1);
    for (int i = 0; i < k; i++) begin
      chk({24'h0, transport.cap[i][7:0]}, 32'h0);
      p = transport.cap[i][8] ^ transport.cap[i + 1][8];
      if (i + 1 < k) chk({31'h0, p}, 32'h1);
    end
    check_frame(k);
    beginning_of_tape <= 1'b0;
    $display("test burst done");
  endtask : test_burst
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, frame_count_overflow} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    beginning_of_tape = 1'b0;
    char_data = 8'h03;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_regs;
    test_record;
    test_mark;
    test_burst;
    tally_and_finish;
  end
endmodule : pe_tape_write_framer_tb
